// [src/rx_cfg_consts.svh]
// constants of the receiver output and requantizer configuration bank
// assumes inclusion by bare name from the package and the bank module
`ifndef RX_CFG_CONSTS_SVH
`define RX_CFG_CONSTS_SVH

// ==========================================
// channel count, serial frame layout and synchroniser depth
`define CHANNEL_COUNT 4
`define FRAME_INSTR_LAST 5'h0F
`define FRAME_DATA_FIRST 5'h10
`define FRAME_DATA_LAST 5'h17
`define FRAME_DONE 5'h18
`define INSTR_READ_BIT 15
`define SYNC_DEPTH 3

// ==========================================
// register offsets
`define REG_CHANNEL_INDEX 13'h0005
`define REG_OUTPUT_FORMAT 13'h0014
`define REG_OUTPUT_DRIVE 13'h0015
`define REG_CLOCK_PHASE 13'h0016
`define REG_CLOCK_DELAY 13'h0017
`define REG_REFERENCE_SELECT 13'h0018
`define REG_SIGNATURE_LOW 13'h0024
`define REG_SIGNATURE_HIGH 13'h0025
`define REG_SYNC_CONTROL 13'h003A
`define REG_REQUANT_CONTROL 13'h003C
`define REG_REQUANT_TUNING 13'h003E

// ==========================================
// writable bit masks, reserved bits are zero
`define MASK_CHANNEL_INDEX 8'h0F
`define MASK_OUTPUT_FORMAT 8'h17
`define MASK_OUTPUT_DRIVE 8'h0F
`define MASK_CLOCK_PHASE 8'h80
`define MASK_CLOCK_DELAY 8'h9F
`define MASK_REFERENCE_SELECT 8'h1F
`define MASK_SYNC_CONTROL 8'h03
`define MASK_REQUANT_CONTROL 8'h1F
`define MASK_REQUANT_TUNING 8'h3F

// ==========================================
// reset values
`define RST_CHANNEL_INDEX 8'h0F
`define RST_OUTPUT_DRIVE 8'h01
`define RST_REQUANT_TUNING 8'h1C
`define RST_ZERO 8'h00

// ==========================================
// field positions
`define BIT_MASTER_SYNC 0
`define BIT_DIVIDER_SYNC 1
`define BIT_REQUANT_ENABLE 0
`define BIT_PIN_DISABLE 4
`define BIT_CLOCK_INVERT 7
`define BIT_DELAY_ENABLE 7
`define MODE_MSB 3
`define MODE_LSB 1
`define TUNE_MSB 5
`define DELAY_CODE_MSB 4

// ==========================================
// requantizer modes, tuning word limits and step sizes
`define MODE_BW22 3'h0
`define MODE_BW33 3'h1
`define TUNE_COUNT_BW22 6'h39
`define TUNE_COUNT_BW33 6'h22
`define TUNE_STEP_PERMILLE 5
`define DELAY_STEP_PS 100

`endif

// [src/rx_cfg_pkg.sv]
// types of the receiver configuration bank
// assumes the constants header sits beside it
package rx_cfg_pkg;
`include "rx_cfg_consts.svh"

    // ==========================================
    // whole state of the bank
    typedef struct packed {
        logic [2:0] sclk_sync;  // serial clock synchroniser
        logic [2:0] csb_sync;  // chip select synchroniser
        logic [2:0] sdio_sync;  // data pin synchroniser
        logic [2:0] pulse_sync;  // external sync pulse synchroniser
        logic [2:0] pin_sync;  // passband width pin synchroniser
        logic sclk_f;  // filtered levels
        logic csb_n_f;
        logic sdio_f;
        logic pulse_f;
        logic pin_f;
        logic [4:0] bit_cnt;  // bits seen in the frame
        logic [15:0] shift_in;  // incoming bits
        logic [7:0] shift_out;  // outgoing read byte
        logic [12:0] addr;  // latched register address
        logic is_read;  // frame is a read
        logic sdio_out;  // data pin drive value
        logic sdio_oe;  // data pin drive enable
        logic [7:0] chan_index;  // channel select
        logic [7:0] ref_sel;  // global reference select
        logic [7:0] sync_ctl;  // global sync control
        logic [`CHANNEL_COUNT-1:0][7:0] fmt;  // per channel registers
        logic [`CHANNEL_COUNT-1:0][7:0] drive;
        logic [`CHANNEL_COUNT-1:0][7:0] phase;
        logic [`CHANNEL_COUNT-1:0][7:0] delay;
        logic [`CHANNEL_COUNT-1:0][7:0] rq_ctl;
        logic [`CHANNEL_COUNT-1:0][7:0] tune;
        logic [`CHANNEL_COUNT-1:0] rq_on;  // derived outputs
        logic [`CHANNEL_COUNT-1:0] tune_ok;
        logic [`CHANNEL_COUNT-1:0][5:0] delay_steps;
        logic div_sync;
    } bank_state_type;
endpackage

// [src/rx_cfg_bank.sv]
// register bank for output, reference, sync and requantizer configuration
// assumes a three wire serial port from the host, asynchronous to sys_clk_i
`timescale 1ns/100ps
`include "rx_cfg_consts.svh"

module rx_cfg_bank #(
    parameter int CHANNELS = `CHANNEL_COUNT
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic sclk_i,  // serial clock pin
    input wire logic csb_n_i,  // serial chip select, active low
    input wire logic sdio_i,  // serial data pin, input side
    output logic sdio_o,  // serial data pin, drive value
    output logic sdio_oe_o,  // serial data pin, drive enable
    input wire logic sync_pulse_i,  // external sync pin
    input wire logic passband_width_pin_i,  // requantizer enable pin
    input wire logic [CHANNELS-1:0][15:0] self_test_engine_signature_i,
    output logic divider_sync_o,  // gated pulse to the input clock divider
    output logic [7:0] reference_select_o,
    output logic [CHANNELS-1:0][7:0] output_format_o,
    output logic [CHANNELS-1:0][7:0] output_drive_o,
    output logic [CHANNELS-1:0] output_data_clock_invert_o,
    output logic [CHANNELS-1:0][5:0] output_data_clock_delay_steps_o,
    output logic [CHANNELS-1:0] noise_shaping_requantizer_on_o,
    output logic [CHANNELS-1:0][2:0] noise_shaping_requantizer_mode_o,
    output logic [CHANNELS-1:0][5:0] noise_shaping_requantizer_tuning_o,
    output logic [CHANNELS-1:0] noise_shaping_requantizer_tuning_ok_o
);

    // ==========================================
    // elaboration check, the packed state is sized by the shared channel count
    if (CHANNELS != `CHANNEL_COUNT) begin : g_bad_channels
        $error("channel count must match the package state layout");
    end

    // ==========================================
    // declarations
    rx_cfg_pkg::bank_state_type st_reg;  // registered state
    rx_cfg_pkg::bank_state_type st_next;  // next state
    logic sclk_next;  // filtered levels after this edge
    logic sdio_next;
    logic pulse_next;
    logic sclk_rise;  // serial clock edges
    logic sclk_fall;
    logic wr_fire;  // a write frame completes this cycle
    logic [7:0] wr_data;  // byte written
    logic [12:0] instr_addr;  // address of a finished instruction

    // ==========================================
    // helper functions

    // filter: a change counts once second and third stages agree
    function automatic logic filt(input logic [2:0] s, input logic f);
        filt = (s[1] == s[2]) ? s[2] : f;
    endfunction

    // writable bits of each register, zero for unmapped addresses
    function automatic logic [7:0] wmask(input logic [12:0] a);
        case (a)
            `REG_CHANNEL_INDEX: wmask = `MASK_CHANNEL_INDEX;
            `REG_OUTPUT_FORMAT: wmask = `MASK_OUTPUT_FORMAT;
            `REG_OUTPUT_DRIVE: wmask = `MASK_OUTPUT_DRIVE;
            `REG_CLOCK_PHASE: wmask = `MASK_CLOCK_PHASE;
            `REG_CLOCK_DELAY: wmask = `MASK_CLOCK_DELAY;
            `REG_REFERENCE_SELECT: wmask = `MASK_REFERENCE_SELECT;
            `REG_SYNC_CONTROL: wmask = `MASK_SYNC_CONTROL;
            `REG_REQUANT_CONTROL: wmask = `MASK_REQUANT_CONTROL;
            `REG_REQUANT_TUNING: wmask = `MASK_REQUANT_TUNING;
            default: wmask = `RST_ZERO;
        endcase
    endfunction

    // lowest selected channel answers local reads
    function automatic int first_chan(input logic [7:0] idx);
        first_chan = 0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (idx[i]) begin
                first_chan = i;
            end
        end
    endfunction

    // read answer for an address
    function automatic logic [7:0] rd_value(
        input rx_cfg_pkg::bank_state_type s,
        input logic [12:0] a,
        input logic [CHANNELS-1:0][15:0] sig
    );
        int c;
        c = first_chan(s.chan_index);
        case (a)
            `REG_CHANNEL_INDEX: rd_value = s.chan_index;
            `REG_OUTPUT_FORMAT: rd_value = s.fmt[c];
            `REG_OUTPUT_DRIVE: rd_value = s.drive[c];
            `REG_CLOCK_PHASE: rd_value = s.phase[c];
            `REG_CLOCK_DELAY: rd_value = s.delay[c];
            `REG_REFERENCE_SELECT: rd_value = s.ref_sel;
            `REG_SIGNATURE_LOW: rd_value = sig[c][7:0];
            `REG_SIGNATURE_HIGH: rd_value = sig[c][15:8];
            `REG_SYNC_CONTROL: rd_value = s.sync_ctl;
            `REG_REQUANT_CONTROL: rd_value = s.rq_ctl[c];
            `REG_REQUANT_TUNING: rd_value = s.tune[c];
            default: rd_value = `RST_ZERO;
        endcase
    endfunction

    // tuning word validity per bandwidth mode
    function automatic logic tune_valid(input logic [7:0] ctl, input logic [7:0] tw);
        case (ctl[`MODE_MSB:`MODE_LSB])
            `MODE_BW22: tune_valid = (tw[`TUNE_MSB:0] < `TUNE_COUNT_BW22);
            `MODE_BW33: tune_valid = (tw[`TUNE_MSB:0] < `TUNE_COUNT_BW33);
            default: tune_valid = 1'b0;
        endcase
    endfunction

    // ==========================================
    // next state logic
    always_comb begin
        st_next = st_reg;
        // three stage synchronisers, first stage read only by the second
        st_next.sclk_sync = {st_reg.sclk_sync[1:0], sclk_i};
        st_next.csb_sync = {st_reg.csb_sync[1:0], csb_n_i};
        st_next.sdio_sync = {st_reg.sdio_sync[1:0], sdio_i};
        st_next.pulse_sync = {st_reg.pulse_sync[1:0], sync_pulse_i};
        st_next.pin_sync = {st_reg.pin_sync[1:0], passband_width_pin_i};
        sclk_next = filt(st_reg.sclk_sync, st_reg.sclk_f);
        sdio_next = filt(st_reg.sdio_sync, st_reg.sdio_f);
        pulse_next = filt(st_reg.pulse_sync, st_reg.pulse_f);
        st_next.sclk_f = sclk_next;
        st_next.sdio_f = sdio_next;
        st_next.pulse_f = pulse_next;
        st_next.csb_n_f = filt(st_reg.csb_sync, st_reg.csb_n_f);
        st_next.pin_f = filt(st_reg.pin_sync, st_reg.pin_f);
        sclk_rise = sclk_next & ~st_reg.sclk_f;
        sclk_fall = ~sclk_next & st_reg.sclk_f;
        wr_fire = 1'b0;
        wr_data = {st_reg.shift_in[6:0], sdio_next};
        instr_addr = {st_reg.shift_in[11:0], sdio_next};

        // serial frame: 16 bit instruction then one data byte
        if (st_reg.csb_n_f) begin
            // deselected, frame restarts and pin is released
            st_next.bit_cnt = 5'h00;
            st_next.sdio_oe = 1'b0;
            st_next.is_read = 1'b0;
        end else if (sclk_rise && st_reg.bit_cnt != `FRAME_DONE) begin
            // sample on rising edge
            st_next.shift_in = {st_reg.shift_in[14:0], sdio_next};
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            if (st_reg.bit_cnt == `FRAME_INSTR_LAST) begin
                // instruction complete, latch address and read data
                st_next.is_read = st_reg.shift_in[`INSTR_READ_BIT - 1];
                st_next.addr = instr_addr;
                st_next.shift_out = rd_value(st_reg, instr_addr, self_test_engine_signature_i);
            end else if (st_reg.bit_cnt == `FRAME_DATA_LAST && !st_reg.is_read) begin
                wr_fire = 1'b1;
            end
        end else if (sclk_fall && st_reg.is_read && st_reg.bit_cnt >= `FRAME_DATA_FIRST
                     && st_reg.bit_cnt <= `FRAME_DATA_LAST) begin
            // drive read data on falling edge, msb first
            st_next.sdio_out = st_reg.shift_out[7];
            st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
            st_next.sdio_oe = 1'b1;
        end

        // register write, reserved bits forced to zero
        if (wr_fire) begin
            case (st_reg.addr)
                `REG_CHANNEL_INDEX: st_next.chan_index = wr_data & wmask(st_reg.addr);
                `REG_REFERENCE_SELECT: st_next.ref_sel = wr_data & wmask(st_reg.addr);
                `REG_SYNC_CONTROL: st_next.sync_ctl = wr_data & wmask(st_reg.addr);
                default: begin
                    // local registers, only indexed channels take the write
                    for (int c = 0; c < CHANNELS; c++) begin
                        if (st_reg.chan_index[c]) begin
                            case (st_reg.addr)
                                `REG_OUTPUT_FORMAT: st_next.fmt[c] = wr_data & wmask(st_reg.addr);
                                `REG_OUTPUT_DRIVE: st_next.drive[c] = wr_data & wmask(st_reg.addr);
                                `REG_CLOCK_PHASE: st_next.phase[c] = wr_data & wmask(st_reg.addr);
                                `REG_CLOCK_DELAY: st_next.delay[c] = wr_data & wmask(st_reg.addr);
                                `REG_REQUANT_CONTROL: begin
                                    st_next.rq_ctl[c] = wr_data & wmask(st_reg.addr);
                                end
                                `REG_REQUANT_TUNING: begin
                                    st_next.tune[c] = wr_data & wmask(st_reg.addr);
                                end
                                default: begin
                                    // signature and unmapped addresses ignore writes
                                    st_next.fmt[c] = st_reg.fmt[c];
                                end
                            endcase
                        end
                    end
                end
            endcase
        end

        // per channel derived outputs
        for (int c = 0; c < CHANNELS; c++) begin
            // pin decides unless the pin disable bit is set
            st_next.rq_on[c] = st_reg.rq_ctl[c][`BIT_PIN_DISABLE]
                ? st_reg.rq_ctl[c][`BIT_REQUANT_ENABLE] : st_reg.pin_f;
            // word index counts half percent steps of the sample rate
            st_next.tune_ok[c] = tune_valid(st_reg.rq_ctl[c], st_reg.tune[c]);
            // code n adds n+1 steps of 100 ps when enabled
            st_next.delay_steps[c] = st_reg.delay[c][`BIT_DELAY_ENABLE]
                ? 6'({1'b0, st_reg.delay[c][`DELAY_CODE_MSB:0]} + 6'h01) : 6'h00;
        end

        // divider sync only on a pulse with both sync bits set
        st_next.div_sync = pulse_next & ~st_reg.pulse_f
            & st_reg.sync_ctl[`BIT_DIVIDER_SYNC]
            & st_reg.sync_ctl[`BIT_MASTER_SYNC];
    end

    // ==========================================
    // state register
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= '0;
            st_reg.sclk_sync <= 3'h0;
            st_reg.csb_sync <= 3'h7;  // idle deselected
            st_reg.csb_n_f <= 1'b1;
            st_reg.chan_index <= `RST_CHANNEL_INDEX;
            for (int c = 0; c < CHANNELS; c++) begin
                st_reg.drive[c] <= `RST_OUTPUT_DRIVE;
                st_reg.tune[c] <= `RST_REQUANT_TUNING;
                st_reg.tune_ok[c] <= 1'b1;  // reset word is valid in mode 000
            end
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================
    // outputs straight from state flip-flops
    assign sdio_o = st_reg.sdio_out;
    assign sdio_oe_o = st_reg.sdio_oe;
    assign divider_sync_o = st_reg.div_sync;
    assign reference_select_o = st_reg.ref_sel;
    assign output_format_o = st_reg.fmt;
    assign output_drive_o = st_reg.drive;
    assign output_data_clock_delay_steps_o = st_reg.delay_steps;
    assign noise_shaping_requantizer_on_o = st_reg.rq_on;
    assign noise_shaping_requantizer_tuning_ok_o = st_reg.tune_ok;
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            // polarity invert bit per channel
            assign output_data_clock_invert_o[g] = st_reg.phase[g][`BIT_CLOCK_INVERT];
            assign noise_shaping_requantizer_mode_o[g] = st_reg.rq_ctl[g][`MODE_MSB:`MODE_LSB];
            assign noise_shaping_requantizer_tuning_o[g] = st_reg.tune[g][`TUNE_MSB:0];
        end
    endgenerate

    // ==========================================
    // assertions
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    a_sync_gate_both: assert property (divider_sync_o |->
        $past(st_reg.sync_ctl[`BIT_DIVIDER_SYNC]) && $past(st_reg.sync_ctl[`BIT_MASTER_SYNC]))
        else $error("divider sync without both enable bits");
    a_master_off_quiet: assert property (!st_reg.sync_ctl[`BIT_MASTER_SYNC]
        |=> !divider_sync_o)
        else $error("sync pulse passed with master sync off");
    a_sync_pulse_pass: assert property (st_reg.sync_ctl[`BIT_DIVIDER_SYNC]
        && st_reg.sync_ctl[`BIT_MASTER_SYNC] && pulse_next && !st_reg.pulse_f |=> divider_sync_o)
        else $error("enabled sync pulse not passed");
    a_pin_mode_used: assert property (!st_reg.rq_ctl[0][`BIT_PIN_DISABLE]
        |=> noise_shaping_requantizer_on_o[0] == $past(st_reg.pin_f))
        else $error("requantizer does not follow the pin");
    a_reg_enable_used: assert property (st_reg.rq_ctl[0][`BIT_PIN_DISABLE]
        |=> noise_shaping_requantizer_on_o[0] == $past(st_reg.rq_ctl[0][0]))
        else $error("requantizer does not follow its enable bit");
    a_tune_limit_22: assert property ((st_reg.rq_ctl[0][3:1] == `MODE_BW22)
        && (st_reg.tune[0][5:0] > 6'h38) |=> !noise_shaping_requantizer_tuning_ok_o[0])
        else $error("tuning word above 56 flagged valid");
    a_tune_limit_33: assert property ((st_reg.rq_ctl[0][3:1] == `MODE_BW33)
        && (st_reg.tune[0][5:0] == 6'h21) |=> noise_shaping_requantizer_tuning_ok_o[0])
        else $error("tuning word 33 flagged invalid");
    a_chan_write_only: assert property (wr_fire && !st_reg.chan_index[0]
        |=> $stable(st_reg.tune[0]) && $stable(st_reg.rq_ctl[0]))
        else $error("unselected channel took a write");
    a_delay_steps_code: assert property (st_reg.delay[0] == 8'h81
        |=> output_data_clock_delay_steps_o[0] == 6'h02)
        else $error("delay code 1 not two steps");
    a_reserved_zero_bits: assert property (st_reg.tune[0][7:6] == 2'h0
        && st_reg.sync_ctl[7:2] == 6'h00)
        else $error("reserved bits hold ones");
    a_read_drive_only: assert property (sdio_oe_o
        |-> st_reg.is_read && !$past(st_reg.csb_n_f))
        else $error("data pin driven outside a read");

    // ==========================================
    // decode, write path and sync pulse checks
    a_sync_single_cycle: assert property (divider_sync_o
        |=> !divider_sync_o)
        else $error("divider sync pulse longer than one cycle");
    a_divider_off_quiet: assert property (!st_reg.sync_ctl[`BIT_DIVIDER_SYNC]
        |=> !divider_sync_o)
        else $error("sync pulse passed with divider sync off");
    a_on_bit_off: assert property (st_reg.rq_ctl[0][`BIT_PIN_DISABLE]
        && !st_reg.rq_ctl[0][`BIT_REQUANT_ENABLE] |=> !noise_shaping_requantizer_on_o[0])
        else $error("requantizer on with its enable bit clear");
    a_mode_other_invalid: assert property (
        st_reg.rq_ctl[0][`MODE_MSB:`MODE_LSB] != `MODE_BW22
        && st_reg.rq_ctl[0][`MODE_MSB:`MODE_LSB] != `MODE_BW33
        |=> !noise_shaping_requantizer_tuning_ok_o[0])
        else $error("unknown requantizer mode flagged valid");
    a_tune_valid_22: assert property (
        st_reg.rq_ctl[0][`MODE_MSB:`MODE_LSB] == `MODE_BW22
        && st_reg.tune[0][`TUNE_MSB:0] < `TUNE_COUNT_BW22
        |=> noise_shaping_requantizer_tuning_ok_o[0])
        else $error("tuning word below 57 flagged invalid");
    a_tune_invalid_33: assert property (
        st_reg.rq_ctl[0][`MODE_MSB:`MODE_LSB] == `MODE_BW33
        && st_reg.tune[0][`TUNE_MSB:0] >= `TUNE_COUNT_BW33
        |=> !noise_shaping_requantizer_tuning_ok_o[0])
        else $error("tuning word above 33 flagged valid");
    a_delay_off_zero: assert property (!st_reg.delay[0][`BIT_DELAY_ENABLE]
        |=> output_data_clock_delay_steps_o[0] == 6'h00)
        else $error("delay applied while disabled");
    a_signature_no_write: assert property (wr_fire
        && (st_reg.addr == `REG_SIGNATURE_LOW || st_reg.addr == `REG_SIGNATURE_HIGH)
        |=> $stable(st_reg.fmt) && $stable(st_reg.rq_ctl) && $stable(st_reg.tune))
        else $error("signature write changed a register");
    a_selected_takes_write: assert property (wr_fire && st_reg.chan_index[1]
        && st_reg.addr == `REG_REQUANT_TUNING
        |=> noise_shaping_requantizer_tuning_o[1] == $past(wr_data[`TUNE_MSB:0]))
        else $error("selected channel missed a tuning write");

endmodule

// [bench/host_port_model.sv]
// host controller model for the three wire serial control port
// assumes the bench resolves the data pin from the device drive enable alone
`timescale 1ns/100ps

module host_port_model (
    input wire logic sys_clk_i,
    input wire logic sdio_i,  // resolved data pin
    output logic sclk_o,  // serial clock, still outside frames
    output logic csb_n_o,  // chip select, active low
    output logic sdio_o  // host drive value
);
    localparam int HALF = 8;  // sys_clk cycles per serial clock level

    // ==========================================
    // idle levels
    initial begin
        sclk_o = 1'b0;
        csb_n_o = 1'b1;
        sdio_o = 1'b0;
    end

    // ==========================================
    // one frame: read flag, address, one data byte, msb first
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                        output logic [7:0] rdat);
        logic [23:0] f;
        f = {rd, 2'b00, a, wd};
        rdat = 8'h00;
        @(negedge sys_clk_i);
        csb_n_o = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            // released while reading: toggle so no stale level passes
            sdio_o = (rd && i < 8) ? ~sdio_o : f[i];
            repeat (HALF) @(negedge sys_clk_i);
            sclk_o = 1'b1;
            if (i < 8) begin
                rdat[i] = sdio_i;  // taken at the host's own rising edge
            end
            repeat (HALF) @(negedge sys_clk_i);
            sclk_o = 1'b0;
        end
        repeat (HALF) @(negedge sys_clk_i);
        csb_n_o = 1'b1;
        repeat (HALF) @(negedge sys_clk_i);
    endtask
endmodule

// [bench/tb_top.sv]
// self-checking bench for the configuration bank
// assumes the host model beside it and the constants header on the path
`timescale 1ns/100ps
`include "rx_cfg_consts.svh"
`define CHECK(what, exp, got) \
    comparisons++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("ERROR %s expected %h seen %h", what, exp, got); \
    end

module tb_top;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic sync_pulse = 1'b0;
    logic bw_pin = 1'b0;
    logic [3:0][15:0] sig = {16'hD4C3, 16'hB2A1, 16'h9788, 16'h6655};
    logic sclk, csb_n, host_sdio, dev_sdio, dev_oe, div_sync;
    logic [3:0] inv, rq_on, ok;
    logic [3:0][2:0] mode;
    logic [3:0][5:0] steps, tune;
    logic [7:0] rd_v;
    logic [7:0] ref_sel;
    logic [3:0][7:0] fmt, drv;
    int n_errors = 0;
    int comparisons = 0;
    int n_sync = 0;
    // register table: address, reset value, value after writing all ones
    logic [12:0] ra [12] = '{13'h0005, 13'h0014, 13'h0015, 13'h0016, 13'h0017, 13'h0018,
        13'h0024, 13'h0025, 13'h003A, 13'h003C, 13'h003E, 13'h0030};
    logic [7:0] rv [12] = '{8'h0F, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h55, 8'h66,
        8'h00, 8'h00, 8'h1C, 8'h00};
    logic [7:0] mv [12] = '{8'h0F, 8'h17, 8'h0F, 8'h80, 8'h9F, 8'h1F, 8'h55, 8'h66,
        8'h03, 8'h1F, 8'h3F, 8'h00};
    // requantizer cases: control, tuning word, mode, word valid
    logic [7:0] qc [5] = '{8'h11, 8'h11, 8'h13, 8'h13, 8'h15};
    logic [7:0] qt [5] = '{8'h38, 8'h39, 8'h21, 8'h22, 8'h00};
    logic [2:0] qm [5] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2};
    logic qk [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    always #50 sys_clk = ~sys_clk;
    // data pin: device drive wins while enabled
    wire sdio_wire = dev_oe ? dev_sdio : host_sdio;
    // counted on the falling edge, mid-cycle, so each one-cycle pulse is seen once
    always @(negedge sys_clk) if (div_sync === 1'b1) n_sync++;

    host_port_model i_host (.sys_clk_i(sys_clk), .sdio_i(sdio_wire), .sclk_o(sclk),
        .csb_n_o(csb_n), .sdio_o(host_sdio));
    rx_cfg_bank i_dut (.sys_clk_i(sys_clk), .reset_i(reset), .sclk_i(sclk),
        .csb_n_i(csb_n), .sdio_i(sdio_wire), .sdio_o(dev_sdio), .sdio_oe_o(dev_oe),
        .sync_pulse_i(sync_pulse), .passband_width_pin_i(bw_pin),
        .self_test_engine_signature_i(sig), .divider_sync_o(div_sync),
        .reference_select_o(ref_sel), .output_format_o(fmt), .output_drive_o(drv),
        .output_data_clock_invert_o(inv), .output_data_clock_delay_steps_o(steps),
        .noise_shaping_requantizer_on_o(rq_on), .noise_shaping_requantizer_mode_o(mode),
        .noise_shaping_requantizer_tuning_o(tune),
        .noise_shaping_requantizer_tuning_ok_o(ok));

    // ==========================================
    // access tasks
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] unused;
        i_host.xfer(1'b0, a, d, unused);
    endtask
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        i_host.xfer(1'b1, a, 8'h00, rd_v);
        `CHECK("register read", exp, rd_v)
    endtask
    task automatic do_reset;
        reset = 1'b1;
        repeat (6) @(negedge sys_clk);
        reset = 1'b0;
        repeat (5) @(negedge sys_clk);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog
    initial begin
        // about 63 frames of some 400 cycles each, with generous margin
        repeat (50000) @(posedge sys_clk);
        n_errors++;
        test_done();
    end

    // ==========================================
    // test sequence
    initial begin
        do_reset();
        `CHECK("tuning ok at reset", 4'hF, ok)
        for (int i = 0; i < 12; i++) begin
            rd_chk(ra[i], rv[i]);
            wr(ra[i], 8'hFF);
            rd_chk(ra[i], mv[i]);
        end
        `CHECK("reference select", 8'h1F, ref_sel)
        `CHECK("output format", {4{8'h17}}, fmt)
        `CHECK("output drive", {4{8'h0F}}, drv)
        $display("test register table done");
        do_reset();
        wr(13'h0005, 8'h02);
        wr(13'h0016, 8'h80);
        `CHECK("clock invert", 4'b0010, inv)
        rd_chk(13'h0024, 8'h88);
        rd_chk(13'h0025, 8'h97);
        wr(13'h0005, 8'h0F);
        wr(13'h0016, 8'h00);
        `CHECK("clock invert", 4'b0000, inv)
        wr(13'h0017, 8'h01);
        `CHECK("delay off", 6'h00, steps[0])
        wr(13'h0017, 8'h81);
        `CHECK("delay code 1", 6'h02, steps[2])
        wr(13'h0017, 8'h9E);
        `CHECK("delay code 30", 6'h1F, steps[3])
        $display("test channel index and clock done");
        bw_pin = 1'b1;
        repeat (8) @(negedge sys_clk);
        `CHECK("pin enables", 4'hF, rq_on)
        wr(13'h003C, 8'h01);
        bw_pin = 1'b0;
        repeat (8) @(negedge sys_clk);
        `CHECK("enable bit ignored", 4'h0, rq_on)
        wr(13'h003C, 8'h11);
        `CHECK("register enables", 4'hF, rq_on)
        bw_pin = 1'b1;
        wr(13'h003C, 8'h10);
        `CHECK("register disables", 4'h0, rq_on)
        for (int i = 0; i < 5; i++) begin
            wr(13'h003C, qc[i]);
            wr(13'h003E, qt[i]);
            `CHECK("mode", qm[i], mode[1])
            `CHECK("tuning word", qt[i][5:0], tune[1])
            `CHECK("word valid", qk[i], ok[1])
        end
        $display("test requantizer done");
        for (int c = 0; c < 4; c++) begin
            wr(13'h003A, 8'(c));
            n_sync = 0;
            sync_pulse = 1'b1;
            repeat (8) @(negedge sys_clk);
            sync_pulse = 1'b0;
            repeat (8) @(negedge sys_clk);
            `CHECK("sync pulses", (c == 3) ? 1 : 0, n_sync)
        end
        wr(13'h003A, 8'h00);
        $display("test sync done");
        test_done();
    end
endmodule
